//--- shared/rx_irq_defines.svh
// Purpose: register offsets, field positions and reset values
// Assumes: byte-wide register port, offsets as printed
// Notes:   definitions only, no logic
`ifndef RX_IRQ_DEFINES_SVH
`define RX_IRQ_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ADDR_CONFIG        6'h05
`define ADDR_SERDES_CTL    6'h06
`define ADDR_RX_INT_EN     6'h07
`define ADDR_RX_INT_STAT   6'h08
`define ADDR_RX_DATA_A     6'h09
`define ADDR_RX_DATA_B     6'h0b

// ****************************************************************
// reset values and writable masks
// ****************************************************************
`define RST_CONFIG         8'h01
`define RST_SERDES_CTL     8'h03
`define RST_RX_INT_EN      8'h00
`define MASK_CONFIG        8'h1b
`define MASK_SERDES_CTL    8'h0f

// ****************************************************************
// field positions
// ****************************************************************
`define EOF_LEN_MSB        2
`define EOF_LEN_LSB        0
`define IRQ_SEL_MSB        1
`define IRQ_SEL_LSB        0
// per-channel nibble in enable and status registers
`define BIT_FULL           0
`define BIT_EOF            1
`define BIT_FLOW           2
`define BIT_UNDER          3
`define BIT_VALID          3
`define BITS_PER_CHAN      4

// ****************************************************************
// interrupt pin drive codes
// ****************************************************************
`define IRQ_OPEN_DRAIN     2'h3
`define IRQ_OPEN_SOURCE    2'h2
`define IRQ_PUSH_HIGH      2'h1
`define IRQ_PUSH_LOW       2'h0

`endif

//--- shared/rx_irq_pkg.sv
// Purpose: shared types of the receive interrupt block
// Assumes: two receive channels, index 0 is A and 1 is B
// Notes:   constants live in rx_irq_defines.svh
package rx_irq_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [5:0] reg_addr_t;
  typedef logic [1:0] chan_vec_t;
  typedef logic [2:0] bit_cnt_t;
  typedef logic [3:0] gap_cnt_t;
endpackage : rx_irq_pkg

//--- rtl/rx_irq_ctrl.sv
// Purpose: receive data holding registers and interrupt gating
// Assumes: receivers give one strobe per bit time, valid or not
// Notes:   reads return data on the cycle after the read strobe
`timescale 1ns/1ps
`include "rx_irq_defines.svh"

module rx_irq_ctrl (
  input  wire logic                  i_clock,
  input  wire logic                  i_reset_n,
  input  wire rx_irq_pkg::reg_addr_t i_reg_addr,
  input  wire rx_irq_pkg::byte_t     i_reg_wdata,
  input  wire logic                  i_reg_write,
  input  wire logic                  i_reg_read,
  input  wire rx_irq_pkg::chan_vec_t i_rx_bit_strobe,
  input  wire rx_irq_pkg::chan_vec_t i_rx_bit_valid,
  input  wire rx_irq_pkg::chan_vec_t i_rx_bit_data,
  output logic                       o_reg_rdata_valid,
  output rx_irq_pkg::byte_t          o_reg_rdata,
  output logic                       o_irq,
  output logic                       o_irq_oe
);
  import rx_irq_pkg::*;

  // ****************************************************************
  // control registers
  // ****************************************************************
  byte_t     config_q;
  byte_t     serdes_ctl_q;
  byte_t     int_en_q;
  logic      [2:0] eof_len;
  logic      [1:0] irq_sel;

  assign eof_len = serdes_ctl_q[`EOF_LEN_MSB:`EOF_LEN_LSB];
  assign irq_sel = config_q[`IRQ_SEL_MSB:`IRQ_SEL_LSB];

  // reserved bits are masked so they always read back as zero
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      config_q     <= `RST_CONFIG;
      serdes_ctl_q <= `RST_SERDES_CTL;
      int_en_q     <= `RST_RX_INT_EN;
    end else if (i_reg_write) begin
      if (i_reg_addr == `ADDR_CONFIG) begin
        config_q <= i_reg_wdata & `MASK_CONFIG;
      end
      if (i_reg_addr == `ADDR_SERDES_CTL) begin
        serdes_ctl_q <= i_reg_wdata & `MASK_SERDES_CTL;
      end
      if (i_reg_addr == `ADDR_RX_INT_EN) begin
        int_en_q <= i_reg_wdata;
      end
    end
  end

  // ****************************************************************
  // per-channel receive assembly and condition flags
  // ****************************************************************
  byte_t     shift_q   [2];
  byte_t     data_q    [2];
  bit_cnt_t  bit_cnt_q [2];
  gap_cnt_t  gap_q     [2];
  chan_vec_t seen_q;
  chan_vec_t full_q;
  chan_vec_t eof_q;
  chan_vec_t over_q;
  chan_vec_t under_q;
  chan_vec_t valid_ev;
  chan_vec_t invalid_ev;
  chan_vec_t eof_ev;
  chan_vec_t byte_done;
  chan_vec_t load;
  chan_vec_t data_rd;
  logic      stat_rd;

  // data register address of a channel
  function automatic reg_addr_t data_addr(input int unsigned ch);
    data_addr = (ch == 0) ? `ADDR_RX_DATA_A : `ADDR_RX_DATA_B;
  endfunction : data_addr

  assign stat_rd = i_reg_read && (i_reg_addr == `ADDR_RX_INT_STAT);

  for (genvar c = 0; c < 2; c++) begin : g_chan
    gap_cnt_t gap_next;
    byte_t    load_val;

    // gap counts only once a frame has begun with a valid bit
    assign valid_ev[c]   = i_rx_bit_strobe[c] && i_rx_bit_valid[c];
    assign invalid_ev[c] = i_rx_bit_strobe[c] && !i_rx_bit_valid[c]
                           && seen_q[c];
    assign gap_next      = gap_q[c] + 4'h1;
    // count must exceed the length, so length zero fires at once
    assign eof_ev[c]     = invalid_ev[c]
                           && (gap_next > {1'b0, eof_len});
    assign byte_done[c]  = valid_ev[c] && (bit_cnt_q[c] == 3'h7);
    // a partial byte is pushed out at end of frame
    assign load[c]       = byte_done[c]
                           || (eof_ev[c] && (bit_cnt_q[c] != 3'h0));
    assign load_val      = byte_done[c]
                           ? {shift_q[c][6:0], i_rx_bit_data[c]}
                           : shift_q[c];
    assign data_rd[c]    = i_reg_read && (i_reg_addr == data_addr(c));

    // bit assembly, msb first
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        shift_q[c]   <= 8'h00;
        bit_cnt_q[c] <= 3'h0;
        gap_q[c]     <= 4'h0;
        seen_q[c]    <= 1'b0;
      end else if (valid_ev[c]) begin
        // a finished byte leaves no stale bits for a later partial one
        shift_q[c]   <= byte_done[c] ? 8'h00
                                     : {shift_q[c][6:0], i_rx_bit_data[c]};
        bit_cnt_q[c] <= bit_cnt_q[c] + 3'h1;
        gap_q[c]     <= 4'h0;
        seen_q[c]    <= 1'b1;
      end else if (eof_ev[c]) begin
        shift_q[c]   <= 8'h00;
        bit_cnt_q[c] <= 3'h0;
        gap_q[c]     <= 4'h0;
        seen_q[c]    <= 1'b0;
      end else if (invalid_ev[c]) begin
        gap_q[c]     <= gap_next;
      end
    end

    // holding register; a load in the read cycle keeps it full
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        data_q[c] <= 8'h00;
        full_q[c] <= 1'b0;
      end else if (load[c]) begin
        data_q[c] <= load_val;
        full_q[c] <= 1'b1;
      end else if (data_rd[c]) begin
        full_q[c] <= 1'b0;
      end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        eof_q[c]   <= 1'b0;
        over_q[c]  <= 1'b0;
        under_q[c] <= 1'b0;
      end else begin
        if (eof_ev[c]) begin
          eof_q[c] <= 1'b1;
        end else if (stat_rd) begin
          eof_q[c] <= 1'b0;
        end
        if (load[c] && full_q[c] && !data_rd[c]) begin
          over_q[c] <= 1'b1;
        end else if (stat_rd) begin
          over_q[c] <= 1'b0;
        end
        if (data_rd[c] && !full_q[c]) begin
          under_q[c] <= 1'b1;
        end else if (stat_rd) begin
          under_q[c] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // interrupt gating and pin drive
  // ****************************************************************
  byte_t cond;
  logic  irq_active_d;
  logic  irq_active_q;

  // same bit order as the enable register: B in the upper nibble
  assign cond = {under_q[1], over_q[1], eof_q[1], full_q[1],
                 under_q[0], over_q[0], eof_q[0], full_q[0]};
  assign irq_active_d = |(cond & int_en_q);

  // pin levels are registered so the pin never glitches
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_active_q <= 1'b0;
      o_irq        <= 1'b0;
      o_irq_oe     <= 1'b1;
    end else begin
      irq_active_q <= irq_active_d;
      case (irq_sel)
        `IRQ_OPEN_DRAIN: begin
          o_irq    <= 1'b0;
          o_irq_oe <= irq_active_d;
        end
        `IRQ_OPEN_SOURCE: begin
          o_irq    <= 1'b1;
          o_irq_oe <= irq_active_d;
        end
        `IRQ_PUSH_HIGH: begin
          o_irq    <= irq_active_d;
          o_irq_oe <= 1'b1;
        end
        default: begin
          o_irq    <= !irq_active_d;
          o_irq_oe <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  byte_t status;
  byte_t rd_mux;

  // status nibble per channel: valid, flow violation, eof, full
  assign status = {seen_q[1], over_q[1] | under_q[1], eof_q[1], full_q[1],
                   seen_q[0], over_q[0] | under_q[0], eof_q[0], full_q[0]};

  // unmapped offsets read as zero
  always_comb begin
    case (i_reg_addr)
      `ADDR_CONFIG:      rd_mux = config_q;
      `ADDR_SERDES_CTL:  rd_mux = serdes_ctl_q;
      `ADDR_RX_INT_EN:   rd_mux = int_en_q;
      `ADDR_RX_INT_STAT: rd_mux = status;
      `ADDR_RX_DATA_A:   rd_mux = data_q[0];
      `ADDR_RX_DATA_B:   rd_mux = data_q[1];
      default:           rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata       <= 8'h00;
      o_reg_rdata_valid <= 1'b0;
    end else begin
      o_reg_rdata_valid <= i_reg_read;
      if (i_reg_read) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  property p_under_b;
    data_rd[1] && !full_q[1] |=> under_q[1];
  endproperty
  a_under_b: assert property (p_under_b)
    else $error("channel B empty read did not flag underflow");

  property p_over_a;
    load[0] && full_q[0] && !data_rd[0] |=> over_q[0] && full_q[0];
  endproperty
  a_over_a: assert property (p_over_a)
    else $error("channel A overwrite did not flag overflow");

  property p_eof_zero;
    eof_len == 3'h0 && invalid_ev[0] |=> eof_q[0] && !seen_q[0];
  endproperty
  a_eof_zero: assert property (p_eof_zero)
    else $error("zero gap did not end frame on first invalid bit");

  property p_eof_needs_valid;
    $rose(eof_q[1]) |-> $past(seen_q[1])
      && $past(gap_q[1]) >= {1'b0, $past(eof_len)};
  endproperty
  a_eof_needs_valid: assert property (p_eof_needs_valid)
    else $error("end of frame without valid bit or wrong gap");

  property p_eof_clear;
    stat_rd && !eof_ev[0] |=> !eof_q[0];
  endproperty
  a_eof_clear: assert property (p_eof_clear)
    else $error("status read did not clear end of frame");

  property p_full_on_eof;
    eof_ev[1] && bit_cnt_q[1] != 3'h0 |=> full_q[1]
      && data_q[1] == $past(shift_q[1]);
  endproperty
  a_full_on_eof: assert property (p_full_on_eof)
    else $error("partial byte not loaded at end of frame");

  property p_gate_under_b;
    under_q[1] && int_en_q[7] |=> irq_active_q;
  endproperty
  a_gate_under_b: assert property (p_gate_under_b)
    else $error("enabled channel B underflow gave no request");

  property p_gate_eof_a;
    eof_q[0] && int_en_q[1] |=> irq_active_q;
  endproperty
  a_gate_eof_a: assert property (p_gate_eof_a)
    else $error("enabled channel A end of frame gave no request");

  property p_gate_full_b;
    full_q[1] && int_en_q[4] |=> irq_active_q;
  endproperty
  a_gate_full_b: assert property (p_gate_full_b)
    else $error("enabled channel B full gave no request");

  property p_idle;
    (cond & int_en_q) == 8'h00 |=> !irq_active_q;
  endproperty
  a_idle: assert property (p_idle)
    else $error("request raised with nothing enabled pending");

  property p_open_drain;
    $past(irq_sel) == `IRQ_OPEN_DRAIN |-> !o_irq
      && o_irq_oe == irq_active_q;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin drive wrong");

  property p_push_low;
    $past(irq_sel) == `IRQ_PUSH_LOW |-> o_irq_oe && o_irq != irq_active_q;
  endproperty
  a_push_low: assert property (p_push_low)
    else $error("inverted push-pull pin drive wrong");

endmodule : rx_irq_ctrl

//--- verification/rx_bit_source.sv
// Purpose: model of the two receivers feeding bit times to the block
// Assumes: one bit time per strobe, driven on the falling clock edge
// Notes:   idle lines show the inverse of the last bit, never a stale copy
`timescale 1ns/1ps

module rx_bit_source (
  input  wire logic            i_clock,
  output rx_irq_pkg::chan_vec_t o_rx_bit_strobe,
  output rx_irq_pkg::chan_vec_t o_rx_bit_valid,
  output rx_irq_pkg::chan_vec_t o_rx_bit_data
);
  import rx_irq_pkg::*;

  // quiet receivers until the bench asks for a bit
  initial begin
    o_rx_bit_strobe = 2'h0;
    o_rx_bit_valid  = 2'h0;
    o_rx_bit_data   = 2'h0;
  end

  // one bit time: strobe for one cycle, then scramble the qualifiers
  // so that a design sampling them outside the strobe is caught
  task automatic send_bit(input logic c, input logic v, input logic d);
    @(negedge i_clock);
    o_rx_bit_strobe[c] = 1'b1;
    o_rx_bit_valid[c]  = v;
    o_rx_bit_data[c]   = d;
    @(negedge i_clock);
    o_rx_bit_strobe[c] = 1'b0;
    o_rx_bit_valid[c]  = ~v;
    o_rx_bit_data[c]   = ~d;
  endtask : send_bit
endmodule : rx_bit_source

//--- verification/testbench.sv
// Purpose: self-checking bench for the receive interrupt block
// Assumes: register port strobes one cycle wide, inputs on falling edge
// Notes:   status compares in the channel loop mask the frame-in-progress bit of a channel
`timescale 1ns/1ps
`include "rx_irq_defines.svh"

module testbench;
  import rx_irq_pkg::*;

  logic      i_clock = 1'b0;
  logic      i_reset_n;
  reg_addr_t i_reg_addr;
  byte_t     i_reg_wdata;
  logic      i_reg_write;
  logic      i_reg_read;
  chan_vec_t rx_strobe;
  chan_vec_t rx_valid;
  chan_vec_t rx_data;
  logic      rdata_valid;
  byte_t     rdata;
  logic      irq;
  logic      irq_oe;
  int        fail_count = 0;
  int        samples_checked = 0;
  byte_t     r;
  byte_t     fm;
  reg_addr_t da;
  int        s;

  // 20 MHz device clock
  always #25 i_clock = ~i_clock;

  rx_bit_source i_rx_bit_source (
    .i_clock         (i_clock),
    .o_rx_bit_strobe (rx_strobe),
    .o_rx_bit_valid  (rx_valid),
    .o_rx_bit_data   (rx_data)
  );

  rx_irq_ctrl i_rx_irq_ctrl (
    .i_clock           (i_clock),
    .i_reset_n         (i_reset_n),
    .i_reg_addr        (i_reg_addr),
    .i_reg_wdata       (i_reg_wdata),
    .i_reg_write       (i_reg_write),
    .i_reg_read        (i_reg_read),
    .i_rx_bit_strobe   (rx_strobe),
    .i_rx_bit_valid    (rx_valid),
    .i_rx_bit_data     (rx_data),
    .o_reg_rdata_valid (rdata_valid),
    .o_reg_rdata       (rdata),
    .o_irq             (irq),
    .o_irq_oe          (irq_oe)
  );

  // ****************************************************************
  // compare, access and closing tasks
  // ****************************************************************
  task automatic chk8(input byte_t got, input byte_t exp, input byte_t m);
    samples_checked++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input reg_addr_t a, input byte_t d);
    @(negedge i_clock);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_write = 1'b1;
    @(negedge i_clock);
    i_reg_write = 1'b0;
  endtask : wr

  // bounded wait for the answer pulse; reads have side effects, so one
  // strobe only
  task automatic rd(input reg_addr_t a, output byte_t d);
    int n;
    n = 0;
    @(negedge i_clock);
    i_reg_addr = a;
    i_reg_read = 1'b1;
    @(negedge i_clock);
    i_reg_read = 1'b0;
    while (rdata_valid !== 1'b1 && n < 4) begin
      @(negedge i_clock);
      n++;
    end
    chk1(rdata_valid, 1'b1);
    d = rdata;
  endtask : rd

  task automatic settle();
    repeat (3) @(negedge i_clock);
  endtask : settle

  // bytes go out most significant bit first
  task automatic send_byte(input logic c, input byte_t b);
    for (int i = 7; i >= 0; i--) i_rx_bit_source.send_bit(c, 1'b1, b[i]);
  endtask : send_byte

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // a hang is cut short long after the few hundred cycles of the tests
  initial begin
    repeat (20000) @(posedge i_clock);
    fail_count++;
    tally_and_finish();
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    i_reset_n   = 1'b0;
    i_reg_addr  = 6'h00;
    i_reg_wdata = 8'h00;
    i_reg_write = 1'b0;
    i_reg_read  = 1'b0;
    repeat (20) @(negedge i_clock);
    i_reset_n = 1'b1;
    rd(`ADDR_RX_INT_EN, r);
    chk8(r, `RST_RX_INT_EN, 8'hff);
    rd(`ADDR_CONFIG, r);
    chk8(r, `RST_CONFIG, 8'hff);
    rd(`ADDR_SERDES_CTL, r);
    chk8(r, `RST_SERDES_CTL, 8'hff);
    rd(`ADDR_RX_INT_STAT, r);
    chk8(r, 8'h00, 8'hff);
    rd(6'h3f, r);
    chk8(r, 8'h00, 8'hff);
    chk1(irq, 1'b0);
    // both channels share one sequence; channel B sits in the top nibble
    for (int c = 0; c < 2; c++) begin
      s  = 4 * c;
      fm = 8'h07 << s;
      da = c ? `ADDR_RX_DATA_B : `ADDR_RX_DATA_A;
      // invalid bits before any valid bit start nothing
      wr(`ADDR_SERDES_CTL, 8'h00);
      i_rx_bit_source.send_bit(c[0], 1'b0, 1'b0);
      i_rx_bit_source.send_bit(c[0], 1'b0, 1'b1);
      settle();
      rd(`ADDR_RX_INT_STAT, r);
      chk8(r, 8'h00, fm);
      // full byte, gated by its enable bit
      wr(`ADDR_RX_INT_EN, 8'h01 << s);
      send_byte(c[0], 8'ha5 ^ c[7:0]);
      settle();
      chk1(irq, 1'b1);
      wr(`ADDR_RX_INT_EN, 8'h00);
      settle();
      chk1(irq, 1'b0);
      rd(`ADDR_RX_INT_STAT, r);
      chk8(r, 8'h01 << s, fm);
      rd(da, r);
      chk8(r, 8'ha5 ^ c[7:0], 8'hff);
      wr(`ADDR_RX_INT_EN, 8'h01 << s);
      settle();
      chk1(irq, 1'b0);
      // second byte lands over an unread one
      wr(`ADDR_RX_INT_EN, 8'h04 << s);
      send_byte(c[0], 8'h3c);
      send_byte(c[0], 8'hc3);
      settle();
      chk1(irq, 1'b1);
      rd(`ADDR_RX_INT_STAT, r);
      chk8(r, 8'h05 << s, fm);
      settle();
      chk1(irq, 1'b0);
      rd(da, r);
      chk8(r, 8'hc3, 8'hff);
      // empty read: the overflow enable must not pass an underflow
      rd(da, r);
      chk8(r, 8'hc3, 8'hff);
      settle();
      chk1(irq, 1'b0);
      wr(`ADDR_RX_INT_EN, 8'h08 << s);
      settle();
      chk1(irq, 1'b1);
      rd(`ADDR_RX_INT_STAT, r);
      chk8(r, 8'h04 << s, fm);
      settle();
      chk1(irq, 1'b0);
      // end of frame: gap 0 on A, gap 3 on B, partial byte 101
      wr(`ADDR_SERDES_CTL, c ? 8'h03 : 8'h00);
      wr(`ADDR_RX_INT_EN, 8'h02 << s);
      i_rx_bit_source.send_bit(c[0], 1'b1, 1'b1);
      i_rx_bit_source.send_bit(c[0], 1'b1, 1'b0);
      i_rx_bit_source.send_bit(c[0], 1'b1, 1'b1);
      repeat (3 * c) i_rx_bit_source.send_bit(c[0], 1'b0, 1'b0);
      settle();
      chk1(irq, 1'b0);
      i_rx_bit_source.send_bit(c[0], 1'b0, 1'b1);
      settle();
      chk1(irq, 1'b1);
      rd(`ADDR_RX_INT_STAT, r);
      chk8(r, 8'h03 << s, fm);
      settle();
      chk1(irq, 1'b0);
      rd(da, r);
      chk8(r, 8'h05, 8'hff);
    end
    // pin drive codes, with a pending full A and without its enable
    send_byte(1'b0, 8'h11);
    for (int a = 1; a >= 0; a--) begin
      wr(`ADDR_RX_INT_EN, {7'h00, a[0]});
      for (int k = 0; k < 4; k++) begin
        wr(`ADDR_CONFIG, k[7:0]);
        settle();
        chk1(irq_oe, a[0] | (k < 2));
        if (a[0] | (k < 2)) begin
          chk1(irq, a[0] ? (k == 1 || k == 2) : (k == 0));
        end
      end
    end
    tally_and_finish();
  end
endmodule : testbench
